// *** gpal_pkg.sv ***
package gpal_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_HZ          = 125_000_000;
    localparam int MS_TICK_NS      = 1_000_000;
    localparam int MS_TICK_CYC     = MS_TICK_NS / 1000 * (CLK_HZ / 1_000_000);
    localparam int BLINK_HALF_MS   = 333;
    localparam int ARROW_WAIT_S    = 3;
    localparam int ARROW_WAIT_MS   = ARROW_WAIT_S * 1000;
    localparam int MS_CNT_W        = 12;

    ////////////////////////////////////////////////////////////////////////
    // Panel and history
    localparam int NUM_KEYS        = 5;
    localparam int KEY_START       = 0;
    localparam int KEY_MODE        = 1;
    localparam int KEY_STOP        = 2;
    localparam int KEY_UP          = 3;
    localparam int KEY_DOWN        = 4;
    localparam int HIST_DEPTH      = 10;
    localparam int HIST_VIEW       = 4;
    localparam int DISP_W          = 128;
    localparam int DISP_H          = 64;
    localparam int SYM_SIZE        = 8;
    localparam int NUM_SCREENS     = 4;
    localparam logic [1:0] SCR_HIST = 2'h3;
    localparam logic       AUTO_RST = 1'h0;

    typedef enum logic [1:0] {
        GPAL_REC_EVENT = 2'h0,
        GPAL_REC_WARN  = 2'h1,
        GPAL_REC_SHUT  = 2'h2,
        GPAL_REC_ECU   = 2'h3
    } gpal_rec_kind_t;

    typedef struct packed {
        gpal_rec_kind_t kind;
        logic           negative;
        logic           confirmed;
        logic [7:0]     code;
        logic [18:0]    spn;
        logic [15:0]    hours;
    } gpal_rec_t;

endpackage

// *** gpal_key_if.sv ***
`timescale 1ns/100ps
interface gpal_key_if #(parameter int N = 5);
    logic [N-1:0] press;
    logic [N-1:0] held;
    modport src (output press, output held);
    modport dst (input press, input held);
endinterface

// *** gpal_keysync.sv ***
`timescale 1ns/100ps
module gpal_keysync
    import gpal_pkg::*;
#(
    parameter int N = NUM_KEYS
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset,
    input  wire logic [N-1:0] i_keys,
    gpal_key_if.src           keys
);

    logic [N-1:0] s1_q;
    logic [N-1:0] s2_q;
    logic [N-1:0] s3_q;
    logic [N-1:0] held_q;
    logic [N-1:0] press_q;

    // First stage is read only by the second stage
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= i_keys;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A level counts once stages two and three agree
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            held_q  <= '0;
            press_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    held_q[i] <= s3_q[i];
                end
            end
            press_q <= (s2_q & s3_q) & ~held_q;
        end
    end

    assign keys.press = press_q;
    assign keys.held  = held_q;

endmodule

// *** gpal_tick.sv ***
`timescale 1ns/100ps
module gpal_tick
    import gpal_pkg::*;
#(
    parameter int MS_CYC = MS_TICK_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    output logic      o_ms,
    output logic      o_blink
);

    logic [31:0]       div_q;
    logic [MS_CNT_W-1:0] half_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            div_q <= '0;
            o_ms  <= 1'b0;
        end else if (div_q == 32'(MS_CYC - 1)) begin
            div_q <= '0;
            o_ms  <= 1'b1;
        end else begin
            div_q <= div_q + 32'h1;
            o_ms  <= 1'b0;
        end
    end

    // One common phase so every lamp and symbol blinks in step
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            half_q  <= '0;
            o_blink <= 1'b0;
        end else if (o_ms) begin
            if (half_q == MS_CNT_W'(BLINK_HALF_MS - 1)) begin
                half_q  <= '0;
                o_blink <= ~o_blink;
            end else begin
                half_q <= half_q + MS_CNT_W'(1);
            end
        end
    end

endmodule

// *** gpal_top.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Start key starts engine in manual only; commits setup changes
// - Mode key toggles between automatic and manual each press outside setup
// - Stop stops running engine in manual; cancels setup; confirms alarms
// - Up and down keys move screens or entries, or change edited values
// - Engine lamp blinks when starting, cooling, stopping; steady running
// - Mode lamp lit in automatic, dark in manual
// - Alarm lamp blinks on active alarms; steady once shutdown confirmed
// - History holds ten records; four shown at once, newest first
// - Scrolling to older records allowed only three seconds after entry
// - Every logged event carries the running-hours count
// - New warning closes alarm relay, blinks lamp and symbol, logs it
// - Confirming an active warning has no effect
// - Cleared warning opens relay, stops blinking, drops warning symbol
// - Shutdown drops breaker, crank, preheat, fuel; sets halt and relay
// - Start inhibited while any shutdown active or unconfirmed
// - Active unconfirmed shutdown blinks, logs negative; stop key confirms
// - Confirmed shutdown: steady lamp, record confirmed, relay open
// - Cleared unconfirmed shutdown keeps relay closed and lamp blinking
// - Start permitted only when all shutdowns inactive and confirmed
// - Engine unit diagnostics logged with their SPN and FMI values
// - Graphic display is monochrome, 128 by 64 pixels
// - General warning symbol in upper right while any alarm present
module gpal_top
    import gpal_pkg::*;
#(
    parameter int NW     = 8,
    parameter int NS     = 8,
    parameter int MS_CYC = MS_TICK_CYC
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic [NUM_KEYS-1:0] i_keys,
    input  wire logic              i_setup_mode,
    input  wire logic              i_eng_starting,
    input  wire logic              i_eng_cooling,
    input  wire logic              i_eng_stopping,
    input  wire logic              i_eng_running,
    input  wire logic [NW-1:0]     i_warn_active,
    input  wire logic [NS-1:0]     i_shut_active,
    input  wire logic              i_event_valid,
    input  wire logic [7:0]        i_event_code,
    input  wire logic              i_ecu_valid,
    input  wire logic [18:0]       i_ecu_spn,
    input  wire logic [4:0]        i_ecu_fmi,
    input  wire logic [15:0]       i_run_hours,
    input  wire logic              i_gen_breaker_req,
    input  wire logic              i_cranking_req,
    input  wire logic              i_preheat_req,
    input  wire logic              i_fuel_valve_req,
    input  wire logic              i_engine_halt_req,
    input  wire logic [1:0]        i_hist_row,
    output logic                   o_auto_mode,
    output logic                   o_start_req,
    output logic                   o_stop_req,
    output logic                   o_setup_commit,
    output logic                   o_setup_cancel,
    output logic                   o_value_inc,
    output logic                   o_value_dec,
    output logic [1:0]             o_screen,
    output logic [3:0]             o_hist_top,
    output logic [3:0]             o_hist_count,
    output logic                   o_arrow_lit,
    output gpal_rec_t              o_hist_rec,
    output logic                   o_lamp_engine,
    output logic                   o_lamp_mode,
    output logic                   o_lamp_alarm,
    output logic                   o_sym_general,
    output logic                   o_sym_warn,
    output logic                   o_sym_shut,
    output logic [6:0]             o_sym_x,
    output logic [5:0]             o_sym_y,
    output logic                   o_start_inhibit,
    output logic                   o_alarm_relay_out,
    output logic                   o_gen_breaker_out,
    output logic                   o_cranking_out,
    output logic                   o_preheat_out,
    output logic                   o_fuel_valve_out,
    output logic                   o_engine_halt_out
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] low_index(input logic [31:0] v);
        logic [7:0] r;
        r = 8'h0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 8'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] low_onehot(input logic [31:0] v);
        return v & (~v + 32'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Keys and time base

    gpal_key_if #(.N(NUM_KEYS)) key_bus ();

    gpal_keysync #(.N(NUM_KEYS)) u_keys (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_keys    (i_keys),
        .keys      (key_bus.src)
    );

    logic ms_tick;
    logic blink;

    gpal_tick #(.MS_CYC(MS_CYC)) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .o_ms      (ms_tick),
        .o_blink   (blink)
    );

    logic [NUM_KEYS-1:0] press;
    assign press = key_bus.press;

    ////////////////////////////////////////////////////////////////////////
    // Alarm state

    logic [NW-1:0] warn_prev_q;
    logic [NS-1:0] shut_prev_q;
    logic [NS-1:0] shut_unconf_q;
    logic [NW-1:0] warn_rise;
    logic [NS-1:0] shut_rise;
    logic          confirm;
    logic          any_warn;
    logic          any_shut;
    logic          any_unconf;
    logic          inhibit;

    assign warn_rise  = i_warn_active & ~warn_prev_q;
    assign shut_rise  = i_shut_active & ~shut_prev_q;
    assign any_warn   = |i_warn_active;
    assign any_shut   = |i_shut_active;
    assign any_unconf = |shut_unconf_q;
    assign confirm    = press[KEY_STOP] & ~i_setup_mode;
    assign inhibit    = any_shut | any_unconf;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            warn_prev_q <= '0;
            shut_prev_q <= '0;
        end else begin
            warn_prev_q <= i_warn_active;
            shut_prev_q <= i_shut_active;
        end
    end

    // stop confirms; a new shutdown wins over the clear
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            shut_unconf_q <= '0;
        end else begin
            shut_unconf_q <= (confirm ? '0 : shut_unconf_q) | shut_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operating mode and key actions

    logic auto_q;
    logic engine_busy;
    assign engine_busy = i_eng_running | i_eng_starting | i_eng_cooling;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            auto_q <= AUTO_RST;
        end else if (press[KEY_MODE] && !i_setup_mode) begin
            auto_q <= ~auto_q;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_start_req    <= 1'b0;
            o_stop_req     <= 1'b0;
            o_setup_commit <= 1'b0;
            o_setup_cancel <= 1'b0;
            o_value_inc    <= 1'b0;
            o_value_dec    <= 1'b0;
        end else begin
            o_setup_commit <= press[KEY_START] & i_setup_mode;
            // start only with no shutdown pending
            o_start_req    <= press[KEY_START] & ~i_setup_mode & ~auto_q
                              & ~inhibit;
            o_setup_cancel <= press[KEY_STOP] & i_setup_mode;
            o_stop_req     <= press[KEY_STOP] & ~i_setup_mode & ~auto_q
                              & engine_busy;
            o_value_inc    <= press[KEY_UP] & i_setup_mode;
            o_value_dec    <= press[KEY_DOWN] & i_setup_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Screens and history view

    logic [1:0]          screen_q;
    logic [3:0]          top_q;
    logic [3:0]          count_q;
    logic [MS_CNT_W-1:0] arrow_ms_q;
    logic                arrow_done;
    logic                nav_up;
    logic                nav_dn;

    assign arrow_done = (arrow_ms_q == MS_CNT_W'(ARROW_WAIT_MS));
    assign nav_up     = press[KEY_UP] & ~i_setup_mode;
    assign nav_dn     = press[KEY_DOWN] & ~i_setup_mode;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            screen_q <= 2'h0;
            top_q    <= 4'h0;
        end else if (screen_q != SCR_HIST) begin
            if (nav_dn) begin
                screen_q <= screen_q + 2'h1;
                top_q    <= 4'h0;
            end else if (nav_up && screen_q != 2'h0) begin
                screen_q <= screen_q - 2'h1;
            end
        end else if (nav_up) begin
            if (top_q == 4'h0) begin
                screen_q <= screen_q - 2'h1;
            end else begin
                top_q <= top_q - 4'h1;
            end
        end else if (nav_dn && arrow_done
                     && count_q > top_q + 4'(HIST_VIEW)) begin
            top_q <= top_q + 4'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset || screen_q != SCR_HIST) begin
            arrow_ms_q <= '0;
        end else if (ms_tick && !arrow_done) begin
            arrow_ms_q <= arrow_ms_q + MS_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // History log

    gpal_rec_t     hist_q [HIST_DEPTH];
    gpal_rec_t     new_rec;
    logic          log_en;
    logic [NW-1:0] warn_pend_q;
    logic [NS-1:0] shut_pend_q;
    logic          ev_pend_q;
    logic [7:0]    ev_code_q;
    logic          ecu_pend_q;
    logic [18:0]   ecu_spn_q;
    logic [4:0]    ecu_fmi_q;
    logic [NW-1:0] warn_take;
    logic [NS-1:0] shut_take;
    logic          warn_take_used;
    logic          shut_take_used;
    logic          ev_take;
    logic          ecu_take;

    assign warn_take = NW'(low_onehot(32'(warn_pend_q)));
    assign shut_take = NS'(low_onehot(32'(shut_pend_q)));

    // Shutdowns log first, so one cycle of many alarms loses none
    always_comb begin
        new_rec           = '0;
        new_rec.hours     = i_run_hours;
        warn_take_used    = 1'b0;
        shut_take_used    = 1'b0;
        ev_take           = 1'b0;
        ecu_take          = 1'b0;
        log_en            = 1'b1;
        if (|shut_pend_q) begin
            new_rec.kind     = GPAL_REC_SHUT;
            new_rec.negative = 1'b1;
            new_rec.code     = low_index(32'(shut_pend_q));
            shut_take_used   = 1'b1;
        end else if (|warn_pend_q) begin
            new_rec.kind     = GPAL_REC_WARN;
            new_rec.code     = low_index(32'(warn_pend_q));
            warn_take_used   = 1'b1;
        end else if (ecu_pend_q) begin
            new_rec.kind     = GPAL_REC_ECU;
            new_rec.code     = {3'h0, ecu_fmi_q};
            new_rec.spn      = ecu_spn_q;
            ecu_take         = 1'b1;
        end else if (ev_pend_q) begin
            new_rec.kind     = GPAL_REC_EVENT;
            new_rec.code     = ev_code_q;
            ev_take          = 1'b1;
        end else begin
            log_en           = 1'b0;
        end
    end

    // Pending flags: a new arrival wins over the take
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            warn_pend_q <= '0;
            shut_pend_q <= '0;
            ev_pend_q   <= 1'b0;
            ecu_pend_q  <= 1'b0;
            ev_code_q   <= 8'h0;
            ecu_spn_q   <= 19'h0;
            ecu_fmi_q   <= 5'h0;
        end else begin
            warn_pend_q <= (warn_pend_q & ~(warn_take_used ? warn_take : '0))
                           | warn_rise;
            shut_pend_q <= (shut_pend_q & ~(shut_take_used ? shut_take : '0))
                           | shut_rise;
            ev_pend_q   <= (ev_pend_q & ~ev_take) | i_event_valid;
            ecu_pend_q  <= (ecu_pend_q & ~ecu_take) | i_ecu_valid;
            if (i_event_valid) begin
                ev_code_q <= i_event_code;
            end
            if (i_ecu_valid) begin
                ecu_spn_q <= i_ecu_spn;
                ecu_fmi_q <= i_ecu_fmi;
            end
        end
    end

    // ten deep, newest at index zero
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                hist_q[i] <= '0;
            end
            count_q <= 4'h0;
        end else begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                gpal_rec_t r;
                r = (log_en && i > 0) ? hist_q[i-1] : hist_q[i];
                if (log_en && i == 0) begin
                    r = new_rec;
                end
                if (confirm && r.kind == GPAL_REC_SHUT && r.negative
                    && !(log_en && i == 0)) begin
                    r.confirmed = 1'b1;
                end
                hist_q[i] <= r;
            end
            if (log_en && count_q != 4'(HIST_DEPTH)) begin
                count_q <= count_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamps, symbols and outputs

    logic [4:0] row_idx;
    assign row_idx = 5'(top_q) + 5'(i_hist_row);

    // four rows from the view top
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_hist_rec <= '0;
        end else if (row_idx < 5'(HIST_DEPTH)) begin
            o_hist_rec <= hist_q[row_idx[3:0]];
        end else begin
            o_hist_rec <= '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_screen     <= 2'h0;
            o_hist_top   <= 4'h0;
            o_hist_count <= 4'h0;
            o_arrow_lit  <= 1'b0;
            o_auto_mode  <= AUTO_RST;
            o_lamp_mode  <= 1'b0;
            o_sym_x      <= 7'h0;
            o_sym_y      <= 6'h0;
        end else begin
            o_screen     <= screen_q;
            o_hist_top   <= top_q;
            o_hist_count <= count_q;
            o_arrow_lit  <= arrow_done | blink;
            o_auto_mode  <= auto_q;
            o_lamp_mode  <= auto_q;
            o_sym_x      <= 7'(DISP_W - SYM_SIZE);
            o_sym_y      <= 6'(DISP_H - DISP_H);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_lamp_engine <= 1'b0;
            o_lamp_alarm  <= 1'b0;
            o_sym_general <= 1'b0;
            o_sym_warn    <= 1'b0;
            o_sym_shut    <= 1'b0;
        end else begin
            if (i_eng_starting || i_eng_cooling || i_eng_stopping) begin
                o_lamp_engine <= blink;
            end else begin
                o_lamp_engine <= i_eng_running;
            end
            if (any_warn || any_unconf) begin
                o_lamp_alarm <= blink;
            end else begin
                o_lamp_alarm <= any_shut;
            end
            o_sym_general <= any_warn | any_shut | any_unconf;
            o_sym_warn    <= any_warn & blink;
            o_sym_shut    <= any_unconf & blink;
        end
    end

    logic halt;
    assign halt = inhibit;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_start_inhibit   <= 1'b0;
            o_alarm_relay_out <= 1'b0;
            o_gen_breaker_out <= 1'b0;
            o_cranking_out    <= 1'b0;
            o_preheat_out     <= 1'b0;
            o_fuel_valve_out  <= 1'b0;
            o_engine_halt_out <= 1'b0;
        end else begin
            o_start_inhibit   <= inhibit;
            o_alarm_relay_out <= any_warn | any_unconf | (|shut_rise);
            // shutdown drops drives and energises halt
            o_gen_breaker_out <= i_gen_breaker_req & ~halt & ~(|shut_rise);
            o_cranking_out    <= i_cranking_req & ~halt & ~(|shut_rise);
            o_preheat_out     <= i_preheat_req & ~halt & ~(|shut_rise);
            o_fuel_valve_out  <= i_fuel_valve_req & ~halt & ~(|shut_rise);
            o_engine_halt_out <= i_engine_halt_req | halt | (|shut_rise);
        end
    end

endmodule

// *** gpal_chk_asserts.sv ***
`timescale 1ns/100ps
module gpal_chk #(parameter int NW = 8, parameter int NS = 8) (
    input wire logic          i_clk_sys,
    input wire logic          i_reset,
    input wire logic [NW-1:0] i_warn_active,
    input wire logic [NS-1:0] i_shut_active,
    input wire logic          o_auto_mode,
    input wire logic          o_start_req,
    input wire logic          o_stop_req,
    input wire logic          o_sym_general,
    input wire logic          o_start_inhibit,
    input wire logic          o_alarm_relay_out,
    input wire logic          o_cranking_out,
    input wire logic          o_engine_halt_out
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    AST_HALT: assert property (
        $rose(|i_shut_active) |=> o_engine_halt_out)
        else $error("halt not raised");
    AST_CRANK: assert property (|i_shut_active |=> !o_cranking_out)
        else $error("cranking kept on shutdown");
    AST_WRELAY: assert property (
        $rose(|i_warn_active) |=> o_alarm_relay_out)
        else $error("relay open on warning");
    AST_INHIB: assert property (|i_shut_active |=> o_start_inhibit)
        else $error("start not inhibited");
    AST_START: assert property (o_start_req |-> !o_auto_mode)
        else $error("start in auto");
    AST_STOP: assert property (o_stop_req |-> !o_auto_mode)
        else $error("stop in auto");
    AST_SYM: assert property (
        |i_warn_active ##1 |i_warn_active |-> o_sym_general)
        else $error("symbol missing");
    // No halt and no shutdown here means none is left unconfirmed
    AST_WCLR: assert property (
        $fell(|i_warn_active) && !(|i_shut_active)
        && !o_engine_halt_out |=> !o_alarm_relay_out)
        else $error("relay held after clear");
endmodule

// *** gpal_eng_model.sv ***
`timescale 1ns/100ps
module gpal_eng_model (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    input  wire logic i_fuel,
    input  wire logic i_halt,
    output logic      o_running
);
    // Engine runs on fuel unless the halt solenoid is energised
    always_ff @(posedge i_clk_sys) begin
        o_running <= !i_reset && i_fuel && !i_halt;
    end
endmodule

// *** gpal_tb.sv ***
`timescale 1ns/100ps
module testbench
    import gpal_pkg::*;
;
    logic clk = 1'h0, rst = 1'h1, ev = 1'h0, ecu = 1'h0, run;
    logic [4:0] keys = 5'h00;
    logic [7:0] warn = 8'h00, shut = 8'h00;
    logic am, sr, lm, sg, inh, rl, cr, fv, ht, sc, la, gb, ph;
    logic setup = 1'h0, req = 1'h1, hreq = 1'h0;
    logic [1:0] row = 2'h0;
    logic [15:0] hrs = 16'h1234;
    logic [3:0] hc;
    gpal_rec_t hr;
    int n_fail = 0, total_checks = 0, n_start = 0, n_cancel = 0;
    gpal_eng_model eng (.i_clk_sys(clk), .i_reset(rst), .i_fuel(fv),
        .i_halt(ht), .o_running(run));
    gpal_top #(.MS_CYC(10)) uut (.i_clk_sys(clk), .i_reset(rst),
        .i_keys(keys), .i_setup_mode(setup), .i_eng_starting(cr),
        .i_eng_cooling(1'h0), .i_eng_stopping(1'h0), .i_eng_running(run),
        .i_warn_active(warn), .i_shut_active(shut), .i_event_valid(ev),
        .i_event_code(8'h5A), .i_ecu_valid(ecu), .i_ecu_spn(19'h0ABCD),
        .i_ecu_fmi(5'h03), .i_run_hours(hrs), .i_gen_breaker_req(req),
        .i_cranking_req(req), .i_preheat_req(req), .i_fuel_valve_req(req),
        .i_engine_halt_req(hreq), .i_hist_row(row), .o_auto_mode(am),
        .o_start_req(sr), .o_stop_req(), .o_setup_commit(),
        .o_setup_cancel(sc), .o_value_inc(), .o_value_dec(), .o_screen(),
        .o_hist_top(), .o_hist_count(hc), .o_arrow_lit(), .o_hist_rec(hr),
        .o_lamp_engine(), .o_lamp_mode(lm), .o_lamp_alarm(la),
        .o_sym_general(sg), .o_sym_warn(), .o_sym_shut(), .o_sym_x(),
        .o_sym_y(), .o_start_inhibit(inh), .o_alarm_relay_out(rl),
        .o_gen_breaker_out(gb), .o_cranking_out(cr), .o_preheat_out(ph),
        .o_fuel_valve_out(fv), .o_engine_halt_out(ht));
    initial forever #4 clk = ~clk;
    always @(posedge clk) if (sr === 1'h1) n_start++;
    always @(posedge clk) if (sc === 1'h1) n_cancel++;
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task press(input int k);
        keys[k] = 1'h1;
        tick(8);
        keys[k] = 1'h0;
        tick(8);
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", nm, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        end_sim;
    end
    initial begin
        tick(10);
        rst = 1'h0;
        tick(2);
        chk("mode lamp", lm, 1'h0);
        press(KEY_MODE);
        chk("auto", am, 1'h1);
        chk("mode lamp", lm, 1'h1);
        press(KEY_START);
        chk("start in auto", n_start, 0);
        press(KEY_MODE);
        press(KEY_START);
        chk("start in manual", n_start, 1);
        ev = 1'h1;
        tick(1);
        ev = 1'h0;
        ecu = 1'h1;
        tick(1);
        ecu = 1'h0;
        warn = 8'h04;
        tick(3);
        chk("relay", rl, 1'h1);
        chk("symbol", sg, 1'h1);
        press(KEY_STOP);
        chk("relay", rl, 1'h1);
        warn = 8'h00;
        tick(3);
        chk("relay", rl, 1'h0);
        shut = 8'h80;
        tick(3);
        chk("halt", ht, 1'h1);
        chk("cranking", cr, 1'h0);
        chk("fuel", fv, 1'h0);
        chk("breaker", gb, 1'h0);
        chk("preheat", ph, 1'h0);
        chk("relay", rl, 1'h1);
        chk("inhibit", inh, 1'h1);
        chk("count", hc, 4'h4);
        chk("kind", hr.kind, GPAL_REC_SHUT);
        chk("negative", hr.negative, 1'h1);
        chk("hours", hr.hours, 16'h1234);
        press(KEY_STOP);
        chk("confirmed", hr.confirmed, 1'h1);
        chk("alarm lamp", la, 1'h1);
        row = 2'h2;
        tick(2);
        chk("ecu kind", hr.kind, GPAL_REC_ECU);
        chk("ecu spn", hr.spn, 19'h0ABCD);
        chk("ecu fmi", hr.code, 8'h03);
        row = 2'h0;
        tick(2);
        chk("relay", rl, 1'h0);
        chk("inhibit", inh, 1'h1);
        shut = 8'h00;
        tick(3);
        chk("inhibit", inh, 1'h0);
        chk("halt", ht, 1'h0);
        setup = 1'h1;
        press(KEY_MODE);
        chk("mode in setup", am, 1'h0);
        press(KEY_STOP);
        chk("setup cancel", n_cancel, 1);
        end_sim;
    end
endmodule
bind gpal_top gpal_chk #(.NW(NW), .NS(NS)) u_chk (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_warn_active(i_warn_active),
    .i_shut_active(i_shut_active), .o_auto_mode(o_auto_mode),
    .o_start_req(o_start_req), .o_stop_req(o_stop_req),
    .o_sym_general(o_sym_general), .o_start_inhibit(o_start_inhibit),
    .o_alarm_relay_out(o_alarm_relay_out), .o_cranking_out(o_cranking_out),
    .o_engine_halt_out(o_engine_halt_out));
